// ==== hw/lock_mon_defs.svh ====
`ifndef LOCK_MON_DEFS_SVH
`define LOCK_MON_DEFS_SVH
// enhancement register field positions
`define ENH_WIDTH          8
`define ENH_BIT_DOUT_SEL   0
`define ENH_BIT_MAIN_OFF   1
`define ENH_BIT_REF_OFF    2
`define ENH_RESET          8'h00
// lock indicator: consecutive quiet cycles before release
`define LOCK_QUIET_CYCLES  16
`endif

// ==== hw/lock_mon_pkg.sv ====
package lock_mon_pkg;
   typedef enum logic [1:0] {
      PD_IDLE = 2'b00,
      PD_UP   = 2'b01,
      PD_DOWN = 2'b10
   } pd_state_t;
endpackage

// ==== hw/enh_store.sv ====
`timescale 1ns/100ps
`include "lock_mon_defs.svh"
module enh_store #(
   parameter int WIDTH = `ENH_WIDTH
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q;
   logic [WIDTH-1:0] mem_d;
   always_comb begin
      mem_d = wr_en ? wr_data : mem_q;
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_q <= WIDTH'(`ENH_RESET);
      end else begin
         mem_q <= mem_d;
      end
   end
   assign rd_data = mem_q;
endmodule

// ==== hw/lock_monitor.sv ====
`timescale 1ns/100ps
`include "lock_mon_defs.svh"
module lock_monitor #(
   parameter int QUIET = `LOCK_QUIET_CYCLES
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       reference_input,
   input  wire logic       feedback_div,
   input  wire logic       modulus_select,
   input  wire logic       prescaler_raw,
   input  wire logic       enh_enable_n,
   input  wire logic       enh_write,
   input  wire logic [7:0] enh_data,
   output logic            main_divider_monitor,
   output logic            reference_divider_monitor,
   output logic            data_out,
   output logic            lock_filter,
   output logic            phase_up_pulse,
   output logic            phase_down_pulse,
   output logic            charge_pump_source,
   output logic            charge_pump_sink,
   output logic            lock_indicator_o,
   output logic            lock_indicator_oe
);
   if (QUIET < 1 || QUIET > 65535) begin : quiet_range
      $error("QUIET out of range");
   end
   ////////////////////////////////////////////////////////////////////////
   logic       ref_q, fb_q, wr_q;
   logic       ref_d, fb_d, wr_d;
   logic [7:0] enh;
   logic       ref_rise, fb_rise, wr_rise;
   always_comb begin
      ref_d = reference_input;
      fb_d  = feedback_div;
      wr_d  = enh_write;
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_q <= 1'b0;
         fb_q  <= 1'b0;
         wr_q  <= 1'b0;
      end else begin
         ref_q <= ref_d;
         fb_q  <= fb_d;
         wr_q  <= wr_d;
      end
   end
   assign ref_rise = reference_input & ~ref_q;
   assign fb_rise  = feedback_div & ~fb_q;
   assign wr_rise  = enh_write & ~wr_q;
   enh_store #(.WIDTH(8)) u_enh (
      .mclk    (mclk),
      .rst     (rst),
      .wr_en   (wr_rise),
      .wr_data (enh_data),
      .rd_data (enh)
   );
   ////////////////////////////////////////////////////////////////////////
   // phase detector
   lock_mon_pkg::pd_state_t pd_q, pd_d;
   always_comb begin
      pd_d = pd_q;
      unique case (pd_q)
         lock_mon_pkg::PD_IDLE: begin
            if (ref_rise && !fb_rise) begin
               pd_d = lock_mon_pkg::PD_UP;
            end else if (fb_rise && !ref_rise) begin
               pd_d = lock_mon_pkg::PD_DOWN;
            end
         end
         lock_mon_pkg::PD_UP: begin
            if (fb_rise) begin
               pd_d = lock_mon_pkg::PD_IDLE;
            end
         end
         lock_mon_pkg::PD_DOWN: begin
            if (ref_rise) begin
               pd_d = lock_mon_pkg::PD_IDLE;
            end
         end
         default: pd_d = lock_mon_pkg::PD_IDLE;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         pd_q <= lock_mon_pkg::PD_IDLE;
      end else begin
         pd_q <= pd_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs and lock filter
   function automatic logic enh_set(input logic       on,
                                    input logic [7:0] bits,
                                    input int         pos);
      return on & bits[pos];
   endfunction
   logic        enh_on;
   logic        up_d, dn_d, main_d, refm_d, dout_d, oe_d;
   logic [15:0] quiet_q, quiet_d;
   always_comb begin
      enh_on = ~enh_enable_n;
      up_d   = (pd_d == lock_mon_pkg::PD_UP);
      dn_d   = (pd_d == lock_mon_pkg::PD_DOWN);
      main_d = feedback_div
             & ~enh_set(enh_on, enh, `ENH_BIT_MAIN_OFF);
      refm_d = reference_input
             & ~enh_set(enh_on, enh, `ENH_BIT_REF_OFF);
      dout_d = enh_set(enh_on, enh, `ENH_BIT_DOUT_SEL) ?
               prescaler_raw : modulus_select;
      if (up_d | dn_d) begin
         quiet_d = 16'h0000;
      end else if (quiet_q != 16'(QUIET)) begin
         quiet_d = quiet_q + 16'h0001;
      end else begin
         quiet_d = quiet_q;
      end
      oe_d = (quiet_d != 16'(QUIET));
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_up_pulse            <= 1'b0;
         phase_down_pulse          <= 1'b0;
         charge_pump_source        <= 1'b0;
         charge_pump_sink          <= 1'b0;
         lock_filter               <= 1'b0;
         main_divider_monitor      <= 1'b0;
         reference_divider_monitor <= 1'b0;
         data_out                  <= 1'b0;
         quiet_q                   <= 16'h0000;
         lock_indicator_oe         <= 1'b1;
         lock_indicator_o          <= 1'b0;
      end else begin
         phase_up_pulse            <= up_d;
         phase_down_pulse          <= dn_d;
         charge_pump_source        <= up_d;
         charge_pump_sink          <= dn_d;
         lock_filter               <= up_d | dn_d;
         main_divider_monitor      <= main_d;
         reference_divider_monitor <= refm_d;
         data_out                  <= dout_d;
         quiet_q                   <= quiet_d;
         lock_indicator_oe         <= oe_d;
         lock_indicator_o          <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence ref_edge_s;
      ref_rise && !fb_rise && pd_q == lock_mon_pkg::PD_IDLE;
   endsequence
   never_both_a: assert property (
      !(phase_up_pulse && phase_down_pulse))
      else $error("up and down both high");
   up_start_a: assert property (ref_edge_s |=> phase_up_pulse)
      else $error("up pulse missing after reference edge");
   filter_or_a: assert property (
      lock_filter == (phase_up_pulse || phase_down_pulse))
      else $error("filter node not OR of pulses");
   pump_dir_a: assert property (
      charge_pump_source == phase_up_pulse
      && charge_pump_sink == phase_down_pulse)
      else $error("pump direction wrong");
   lock_low_a: assert property (
      lock_filter |-> lock_indicator_oe && !lock_indicator_o)
      else $error("indicator not low while pulses active");
   main_gate_a: assert property (
      !enh_enable_n && enh[`ENH_BIT_MAIN_OFF] |=> !main_divider_monitor)
      else $error("main monitor switching while stopped");
   ref_pass_a: assert property (
      enh_enable_n |=> reference_divider_monitor == $past(reference_input))
      else $error("reference monitor gated while disabled");
   dout_sel_a: assert property (
      enh_enable_n |=> data_out == $past(modulus_select))
      else $error("data out not modulus select");
   enh_cap_a: assert property (
      wr_rise |=> enh == $past(enh_data))
      else $error("enhancement byte not captured");
   // edge conditions of the phase detector
   sequence fb_edge_s;
      fb_rise && !ref_rise && pd_q == lock_mon_pkg::PD_IDLE;
   endsequence
   sequence up_end_s;
      phase_up_pulse && fb_rise;
   endsequence
   sequence down_end_s;
      phase_down_pulse && ref_rise;
   endsequence
   down_start_a: assert property (fb_edge_s |=> phase_down_pulse)
      else $error("down pulse missing after feedback edge");
   up_end_a: assert property (up_end_s |=> !phase_up_pulse)
      else $error("up pulse outlived feedback edge");
   down_end_a: assert property (down_end_s |=> !phase_down_pulse)
      else $error("down pulse outlived reference edge");
   ref_gate_a: assert property (
      !enh_enable_n && enh[`ENH_BIT_REF_OFF] |=> !reference_divider_monitor)
      else $error("reference monitor switching while stopped");
   main_pass_a: assert property (
      enh_enable_n |=> main_divider_monitor == $past(feedback_div))
      else $error("main monitor gated while disabled");
   // lock indicator released only while quiet
   release_hold_a: assert property (
      !lock_indicator_oe |=> lock_indicator_oe == lock_filter)
      else $error("indicator left released state without pulse");
endmodule

// ==== bench/lock_far_side.sv ====
`timescale 1ns/100ps
module lock_far_side (
   input  wire logic od_o,
   input  wire logic od_oe,
   output wire logic lock_indicator
);
   // pull-up holds the released line high
   assign lock_indicator = od_oe ? od_o : 1'b1;
endmodule

// ==== bench/tb_phase_lock_monitor_outputs.sv ====
`timescale 1ns/100ps
module tb_phase_lock_monitor_outputs;
   localparam int QUIET = 4;
   logic        mclk, rst, ref_in, fb, mod_sel, pre, en_n, wr;
   logic [7:0]  data;
   logic        mmon, rmon, dout, filt, up, dn, src, snk, ind_o, ind_oe;
   wire logic   lock_indicator;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   // en_n, enh byte, fb, ref, mod_sel, pre, expected main/ref monitor, dout
   logic [15:0] rows [6] = '{16'h0077, 16'h00d4, 16'h016a, 16'h026c,
                             16'h83ee, 16'h03e9};
   lock_monitor #(.QUIET(QUIET)) u_dut (
      .mclk(mclk), .rst(rst), .reference_input(ref_in), .feedback_div(fb),
      .modulus_select(mod_sel), .prescaler_raw(pre), .enh_enable_n(en_n),
      .enh_write(wr), .enh_data(data), .main_divider_monitor(mmon),
      .reference_divider_monitor(rmon), .data_out(dout),
      .lock_filter(filt), .phase_up_pulse(up), .phase_down_pulse(dn),
      .charge_pump_source(src), .charge_pump_sink(snk),
      .lock_indicator_o(ind_o), .lock_indicator_oe(ind_oe));
   lock_far_side u_far (.od_o(ind_o), .od_oe(ind_oe),
      .lock_indicator(lock_indicator));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic write_enh(input logic [7:0] v);
      data = v;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(1);
   endtask
   task automatic end_sim;
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 2000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      {rst, ref_in, fb, mod_sel, pre, en_n, wr, data} = {7'h42, 8'h00};
      step(3);
      check({up, dn, src, snk}, 4'h0);
      check({filt, ind_oe, mmon | rmon | dout, lock_indicator}, 4'h4);
      rst = 1'b0;
      for (int i = 0; i < 6; i++) begin
         en_n = rows[i][15];
         write_enh(rows[i][14:7]);
         {fb, ref_in, mod_sel, pre} = rows[i][6:3];
         step(2);
         check({1'b0,mmon,rmon,dout}, {1'b0,rows[i][2:0]});
      end
      // strobe held high must not capture twice
      data = 8'h02;
      wr = 1'b1;
      step(1);
      data = 8'h00;
      step(3);
      check({3'h0, mmon}, 4'h0);
      wr = 1'b0;
      step(1);
      wr = 1'b1;
      step(3);
      check({3'h0, mmon}, 4'h1);
      {ref_in, fb, rst} = 3'b001;
      step(1);
      rst = 1'b0;
      ref_in = 1'b1;
      step(1);
      check({up, dn, src, snk}, 4'ha);
      check({filt, ind_oe, lock_indicator, 1'b0}, 4'hc);
      step(2);
      fb = 1'b1;
      step(1);
      check({up, dn, src, snk}, 4'h0);
      {ref_in, fb} = 2'b00;
      step(QUIET + 3);
      check({filt, ind_oe, lock_indicator, 1'b0}, 4'h2);
      fb = 1'b1;
      step(1);
      check({up, dn, src, snk}, 4'h5);
      check({filt, ind_oe, lock_indicator, 1'b0}, 4'hc);
      ref_in = 1'b1;
      step(1);
      check({up, dn, src, snk}, 4'h0);
      {ref_in, fb} = 2'b00;
      step(1);
      {ref_in, fb} = 2'b11;
      step(2);
      check({up, dn, src, snk}, 4'h0);
      end_sim();
   end
endmodule
